// File: core/read_throttle_pkg.sv
package read_throttle_pkg;
   // Register map, byte addresses on a 32-bit APB
   localparam logic [7:0] CTRL_LO_ADDR = 8'hD8;
   localparam logic [7:0] CTRL_HI_ADDR = 8'hDC;
   localparam logic [7:0] SAMPLE_WIN_ADDR = 8'hE0;
   localparam logic [7:0] STATUS_ADDR = 8'hE4;
   // Control field positions (64-bit register)
   localparam int GO_BIT = 0;
   localparam int SEL_LSB = 1;
   localparam int CAP_LSB = 3;
   localparam int WIN_LSB = 15;
   localparam int DUR_LSB = 22;
   localparam int TRIG_LSB = 28;
   localparam int TRIG_SHIFT = 15;
   localparam int WIN_PAD = 4;
   localparam logic [63:0] CTRL_RESET = 64'h0000000000000000;
   localparam logic [63:0] CTRL_WMASK = 64'h000001FFFFFFFFFF;
   localparam logic [31:0] SAMPLE_WIN_RESET = 32'h00000000;
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_COUNTER = 2'h2;

   // Zero-extend the 13-bit threshold before it is shifted up
   function automatic logic [28:0] widen13(input logic [12:0] v);
      return {16'h0000, v};
   endfunction
endpackage

// File: core/window_timer.sv
`timescale 1ns/100ps
// Repeating window timer; pulses done at end of each window
module window_timer
   import read_throttle_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [31:0] length,
   output logic done
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;

   // Count up to length-1, then wrap; length 0 ends every cycle
   always_comb begin
      cnt_next = cnt_reg;
      done = 1'b0;
      if (!run) begin
         cnt_next = 32'h00000000;
      end else if (cnt_reg + 32'h00000001 >= length) begin
         cnt_next = 32'h00000000;
         done = 1'b1;
      end else begin
         cnt_next = cnt_reg + 32'h00000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 32'h00000000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule

// File: core/dram_read_throttle.sv
`timescale 1ns/100ps
// Function
// R1: Global trigger equals 13-bit threshold times two to the fifteenth.
// R2: Counter throttling lasts duration-field count of global sampling windows.
// R3: Monitor window length is window field with four zero bits appended.
// R4: During throttling count hexwords per monitor window, restart each window.
// R5: At per-window cap, block further reads until window ends.
// R6: Per-window cap comes from 12-bit field, 0 to 4095.
// R7: Mode 00 disables the global counter; 01 and 11 reserved.
// R8: Mode 10 enables global counter starting timed throttling periods.
// R9: Go bit cleared stops throttling and resets window and hexword counters.
// R10: In mode 00, go bit set starts throttling until software clears it.
// R11: Sampling window length from own register; global count restarts each.
// R12: Traffic counted in hexwords of sixteen bytes.
module dram_read_throttle
   import read_throttle_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rd_req,
   input wire logic rd_hexword,
   output logic rd_block,
   output logic throttling
);
   logic [63:0] ctrl_reg;
   logic [63:0] ctrl_next;
   logic [31:0] swin_reg;
   logic [31:0] swin_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [28:0] gcount_reg;
   logic [28:0] gcount_next;
   logic [5:0] dur_reg;
   logic [5:0] dur_next;
   logic [11:0] wcount_reg;
   logic [11:0] wcount_next;
   logic blocked_reg;
   logic blocked_next;
   logic active_reg;
   logic active_next;
   logic go;
   logic [1:0] sel;
   logic [11:0] cap;
   logic [10:0] mwin_len;
   logic [5:0] duration;
   logic [28:0] trigger;
   logic gwin_done;
   logic mwin_done;
   logic mwin_run;
   logic hit_trigger;
   logic access;
   logic wr;

   // Field decode
   assign go = ctrl_reg[GO_BIT];
   assign sel = ctrl_reg[SEL_LSB +: 2];
   assign cap = ctrl_reg[CAP_LSB +: 12]; // R6
   assign mwin_len = {ctrl_reg[WIN_LSB +: 7], 4'h0}; // R3
   assign duration = ctrl_reg[DUR_LSB +: 6];
   assign trigger = widen13(ctrl_reg[TRIG_LSB +: 13]) << TRIG_SHIFT; // R1

   // APB handshake: zero wait states, never an error
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_reg;

   // Global sampling window timer runs only in counter mode
   window_timer global_timer (
      .pclk(pclk),
      .presetn(presetn),
      .run(go && sel == SEL_COUNTER),
      .length(swin_reg),
      .done(gwin_done)
   ); // R11

   // Monitor window timer runs while throttling is in effect
   assign mwin_run = active_reg;
   window_timer monitor_timer (
      .pclk(pclk),
      .presetn(presetn),
      .run(mwin_run),
      .length({21'h000000, mwin_len}),
      .done(mwin_done)
   );

   // Register writes and read data
   always_comb begin
      ctrl_next = ctrl_reg;
      swin_next = swin_reg;
      prdata_next = prdata_reg;
      if (wr) begin
         case (paddr)
            CTRL_LO_ADDR: ctrl_next[31:0] = pwdata & CTRL_WMASK[31:0];
            CTRL_HI_ADDR: ctrl_next[63:32] = pwdata & CTRL_WMASK[63:32];
            SAMPLE_WIN_ADDR: swin_next = pwdata;
            default: ;
         endcase
      end
      // Read data latched in setup so it stands through the access phase
      if (psel && !penable && !pwrite) begin
         case (paddr)
            CTRL_LO_ADDR: prdata_next = ctrl_reg[31:0];
            CTRL_HI_ADDR: prdata_next = ctrl_reg[63:32];
            SAMPLE_WIN_ADDR: prdata_next = swin_reg;
            STATUS_ADDR: prdata_next = {18'h00000, blocked_reg, active_reg,
                                        wcount_reg};
            default: prdata_next = 32'h00000000;
         endcase
      end
   end

   // Throttling state: global trigger, duration, per-window count
   always_comb begin
      gcount_next = gcount_reg;
      dur_next = dur_reg;
      wcount_next = wcount_reg;
      blocked_next = blocked_reg;
      active_next = active_reg;
      hit_trigger = 1'b0;
      if (!go || sel[0]) begin
         // Stop and clear window and hexword counters
         active_next = 1'b0; // R7 R9
         wcount_next = 12'h000; // R9
         blocked_next = 1'b0;
         gcount_next = 29'h00000000;
         dur_next = 6'h00;
      end else begin
         if (sel == SEL_COUNTER) begin
            // R8 R11 R12: count hexwords per sampling window
            if (gwin_done) begin
               gcount_next = 29'h00000000; // R11
            end else if (rd_hexword && gcount_reg != {29{1'b1}}) begin
               gcount_next = gcount_reg + 29'h00000001; // R12
            end
            hit_trigger = rd_hexword && !active_reg &&
                          gcount_reg + 29'h00000001 >= trigger; // R1 R8
            if (hit_trigger) begin
               active_next = duration != 6'h00;
               dur_next = duration; // R2
            end else if (active_reg && gwin_done) begin
               if (dur_reg <= 6'h01) begin
                  active_next = 1'b0; // R2
               end
               dur_next = dur_reg - 6'h01;
            end
         end else begin
            // Mode 00: software start, global counter held idle
            gcount_next = 29'h00000000;
            dur_next = 6'h00;
            active_next = 1'b1; // R10
         end
         // R4 R5: per monitor window count and block
         if (!active_reg || mwin_done) begin
            wcount_next = 12'h000; // R4
            blocked_next = 1'b0;
         end else begin
            if (rd_hexword && !blocked_reg) begin
               wcount_next = wcount_reg + 12'h001; // R4
            end
            if (wcount_next >= cap) begin
               blocked_next = 1'b1; // R5
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
         swin_reg <= SAMPLE_WIN_RESET;
         prdata_reg <= 32'h00000000;
         gcount_reg <= 29'h00000000;
         dur_reg <= 6'h00;
         wcount_reg <= 12'h000;
         blocked_reg <= 1'b0;
         active_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         swin_reg <= swin_next;
         prdata_reg <= prdata_next;
         gcount_reg <= gcount_next;
         dur_reg <= dur_next;
         wcount_reg <= wcount_next;
         blocked_reg <= blocked_next;
         active_reg <= active_next;
      end
   end

   // Hold off read requests while capped
   assign rd_block = blocked_reg && rd_req; // R5
   assign throttling = active_reg;

   // Go clear stops throttling and clears the window count
   a_go_clear_stops: assert property (@(posedge pclk) // R9
      disable iff (!presetn)
      !go |=> !active_reg && wcount_reg == 12'h000)
      else $error("throttling not stopped with go clear");

   // Reserved modes keep throttling off
   a_mode_off_idle: assert property (@(posedge pclk) // R7
      disable iff (!presetn)
      sel[0] |=> !active_reg)
      else $error("throttling active in reserved mode");

   // Mode 00 with go set forces throttling on
   a_direct_go_on: assert property (@(posedge pclk) // R10
      disable iff (!presetn)
      go && sel == SEL_OFF |=> active_reg)
      else $error("go did not start direct throttling");

   // Cap reached inside a window sets the block
   a_block_at_cap: assert property (@(posedge pclk) // R5
      disable iff (!presetn)
      active_reg && !mwin_done && wcount_next >= cap && go && !sel[0]
      |=> blocked_reg)
      else $error("cap reached but reads not blocked");

   // Window end clears block and count
   a_block_window_end: assert property (@(posedge pclk) // R4
      disable iff (!presetn)
      mwin_done |=> !blocked_reg && wcount_reg == 12'h000)
      else $error("window end did not restart count");

   // Each passed hexword bumps the window count
   a_count_hexword: assert property (@(posedge pclk) // R4
      disable iff (!presetn)
      active_reg && go && !sel[0] && !mwin_done && rd_hexword
      && !blocked_reg |=> wcount_reg == $past(wcount_reg) + 12'h001)
      else $error("hexword not counted");

   // Trigger starts a period of the programmed length
   a_trigger_start: assert property (@(posedge pclk) // R1
      disable iff (!presetn)
      hit_trigger && duration != 6'h00 |=> active_reg
      && dur_reg == $past(duration))
      else $error("trigger did not start throttling");

   // Sampling window end restarts the global count
   a_gwin_restart: assert property (@(posedge pclk) // R11
      disable iff (!presetn)
      gwin_done |=> gcount_reg == 29'h00000000)
      else $error("global count not restarted");

   // No hold-off unless capped
   a_block_out: assert property (@(posedge pclk) // R5
      disable iff (!presetn)
      rd_req && !blocked_reg |-> !rd_block)
      else $error("read blocked while not capped");

   // Capped state holds off every request
   a_block_gate: assert property (@(posedge pclk) // R5
      disable iff (!presetn)
      rd_req && blocked_reg |-> rd_block)
      else $error("request passed while capped");

   // Window count stays clear outside throttling
   a_no_count_idle: assert property (@(posedge pclk) // R4
      disable iff (!presetn)
      !active_reg |=> wcount_reg == 12'h000)
      else $error("window count moved while idle");

   // Global count idle outside counter mode
   a_gcount_idle: assert property (@(posedge pclk) // R8
      disable iff (!presetn)
      !(go && sel == SEL_COUNTER) |=> gcount_reg == 29'h00000000)
      else $error("global count moved outside counter mode");

   // Global count steps one per hexword
   a_hexword_step: assert property (@(posedge pclk) // R12
      disable iff (!presetn)
      go && sel == SEL_COUNTER && !gwin_done && rd_hexword
      && gcount_reg != {29{1'b1}}
      |=> gcount_reg == $past(gcount_reg) + 29'h00000001)
      else $error("global hexword not counted");

   // Zero duration gives no throttling period
   a_dur_zero_none: assert property (@(posedge pclk) // R2
      disable iff (!presetn)
      hit_trigger && duration == 6'h00 |=> !active_reg)
      else $error("zero duration started throttling");

   // Last sampling window of a period ends it
   a_period_end: assert property (@(posedge pclk) // R2
      disable iff (!presetn)
      go && sel == SEL_COUNTER && active_reg && gwin_done
      && dur_reg <= 6'h01 |=> !active_reg)
      else $error("throttling period overran");

   // Block holds until the window ends
   a_blocked_hold: assert property (@(posedge pclk) // R5
      disable iff (!presetn)
      blocked_reg && active_reg && go && !sel[0] && !mwin_done
      |=> blocked_reg)
      else $error("block released inside window");
endmodule

// File: bench/dram_read_port.sv
`timescale 1ns/100ps
// Read path that asks while wanted, one hexword per granted beat
module dram_read_port (
   input wire logic want,
   input wire logic rd_block,
   output logic rd_req,
   output logic rd_hexword
);
   // Beat only while the request is not held off
   assign rd_req = want;
   assign rd_hexword = want & ~rd_block;
endmodule

// File: bench/dram_read_throttle_tb.sv
`timescale 1ns/100ps
module dram_read_throttle_tb;
   import read_throttle_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, want = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rdv, rnd;
   logic pready, pslverr, rd_req, rd_hexword, rd_block, throttling;
   int failures = 0, checks_done = 0, beats, cap, n;

   dram_read_throttle dram_read_throttle_i(.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rd_req(rd_req), .rd_hexword(rd_hexword),
      .rd_block(rd_block), .throttling(throttling));
   dram_read_port dram_read_port_i(.want(want), .rd_block(rd_block),
      .rd_req(rd_req), .rd_hexword(rd_hexword));

   // Clock
   initial begin
      forever #5 pclk = ~pclk;
   end

   // Low control word: trigger 1, duration 1, window 1
   function automatic logic [31:0] ctrl_lo(input logic [1:0] sel,
      input logic go, input logic [11:0] c);
      return {3'h0, 1'h1, 6'h01, 7'h01, c, sel, go};
   endfunction

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Hexword beats seen over a span of cycles
   task automatic count_beats(input int span);
      beats = 0;
      repeat (span) begin
         @(posedge pclk);
         #1 if (rd_hexword === 1'b1) beats++;
      end
   endtask

   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog
   initial begin
      #800000;
      failures++;
      close_out();
   end

   initial begin
      void'($urandom(32'h5E8C));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then an unmapped place
      apb(1'b0, CTRL_LO_ADDR, 32'h0);
      check(rdv, 32'h00000000);
      apb(1'b0, CTRL_HI_ADDR, 32'h0);
      check(rdv, 32'h00000000);
      apb(1'b0, 8'h10, 32'h0);
      check(rdv, 32'h00000000);
      // Random readback, reserved top bits read zero
      rnd = $urandom;
      apb(1'b1, CTRL_HI_ADDR, rnd);
      apb(1'b0, CTRL_HI_ADDR, 32'h0);
      check(rdv, rnd & 32'h000001FF);
      apb(1'b1, CTRL_HI_ADDR, 32'h0);
      apb(1'b1, SAMPLE_WIN_ADDR, 32'd40000);
      apb(1'b0, SAMPLE_WIN_ADDR, 32'h0);
      check(rdv, 32'd40000);
      // Reserved modes with go set pass every beat
      cap = 1 + $urandom % 8;
      want <= 1'b1;
      apb(1'b1, CTRL_LO_ADDR, ctrl_lo(2'h1, 1'b1, cap[11:0]));
      count_beats(64);
      check(beats, 64);
      apb(1'b1, CTRL_LO_ADDR, ctrl_lo(2'h3, 1'b1, cap[11:0]));
      count_beats(64);
      check(beats, 64);
      // Counter mode: trigger after 32768 hexwords in one window
      apb(1'b1, CTRL_LO_ADDR, ctrl_lo(2'h2, 1'b1, cap[11:0]));
      n = 0;
      while (throttling !== 1'b1 && n < 45000) begin
         @(posedge pclk);
         n++;
      end
      check({31'h0, n >= 32768}, 32'h1);
      check({31'h0, throttling}, 32'h1);
      // Ten 16-clock windows, each capped
      count_beats(160);
      check({31'h0, beats >= 9 * cap && beats <= 11 * cap}, 1);
      // Mode 00 with go set throttles directly
      apb(1'b1, CTRL_LO_ADDR, ctrl_lo(2'h0, 1'b1, cap[11:0]));
      count_beats(160);
      check({31'h0, beats >= 9 * cap && beats <= 11 * cap}, 1);
      check({31'h0, throttling}, 32'h1);
      // Go cleared stops throttling
      apb(1'b1, CTRL_LO_ADDR, ctrl_lo(2'h2, 1'b0, cap[11:0]));
      repeat (2) @(posedge pclk);
      count_beats(32);
      check(beats, 32);
      check({31'h0, throttling}, 32'h0);
      close_out();
   end
endmodule
